// file: bench/asbs_peer.sv
// Behavioural serial peer on the far side of the three-wire link
`timescale 1ns/100ps
`default_nettype none
module asbs_peer (
  input wire logic run, // Clock the link while high
  input wire logic rxLevel, // Level sent to the device
  input wire logic dataFromDut, // Device data output
  output logic sck, // Link clock, parked low between frames
  output logic dataToDut, // Device data input
  output logic [7:0] lastByte // Last eight bits seen on rises
);
  // ****************************************
  // Link clock and data
  // ****************************************
  logic live; // Frame under way, first data bit set up
  initial begin
    sck = 1'b0;
    dataToDut = 1'b0;
    live = 1'b0;
  end
  // 160 ns period; the first half period of a frame only sets up the data
  always begin
    #80;
    if (!run) begin
      // Parked: clock stands low, data shows the inverse of the frame level
      live = 1'b0;
      sck = 1'b0;
      dataToDut = ~rxLevel;
    end else if (!live) begin
      live = 1'b1;
      dataToDut = rxLevel;
    end else begin
      // New data only after a fall, so it is settled at the next rise
      sck = ~sck;
      if (!sck) dataToDut = rxLevel;
    end
  end
  // Capture on rise, MSB first
  always @(posedge sck) lastByte <= {lastByte[6:0], dataFromDut};
endmodule // asbs_peer
`default_nettype wire

// file: bench/auto_serial_buffer_sequencer_bench.sv
// Self-checking bench for the auto serial buffer sequencer
`include "asbs_params.svh"
`timescale 1ns/100ps
`default_nettype none
module auto_serial_buffer_sequencer_bench;
  // ****************************************
  // Signals
  // ****************************************
  typedef struct packed {
    logic rx; // Receive enable
    logic rel; // Repeat bit
    logic [4:0] n; // Byte count
    logic [7:0] intv; // Gap setting
    logic pinFree; // Expected: data input pin released while busy
    logic [7:0] rises; // Expected: link clock rises per sequence
  } asbs_row_t;
  asbs_row_t rows [4] = '{'{1'b1, 1'b0, 5'h10, 8'h00, 1'b0, 8'h9e},
                          '{1'b0, 1'b0, 5'h01, 8'h00, 1'b1, 8'h08},
                          '{1'b0, 1'b0, 5'h05, 8'h85, 1'b1, 8'h40},
                          '{1'b1, 1'b1, 5'h02, 8'h81, 1'b0, 8'h12}};
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sckIn, serialDataIn, serialDataOut, serialInPortMode;
  logic xferInProgress, serialDoneIrq, rxLevel;
  logic [7:0] lastByte;
  int errors = 0;
  int samples_checked = 0;
  int sckRises = 0; // Link clock rises seen, bytes plus gaps
  asbs_top u_asbs_top (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sckIn(sckIn), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut), .serialInPortMode(serialInPortMode),
    .xferInProgress(xferInProgress), .serialDoneIrq(serialDoneIrq));
  // Peer clocks only while a sequence runs
  asbs_peer u_asbs_peer (.run(xferInProgress), .rxLevel(rxLevel),
    .dataFromDut(serialDataOut), .sck(sckIn), .dataToDut(serialDataIn),
    .lastByte(lastByte));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Every rise is either a data bit or a counted gap clock
  always @(posedge sckIn) sckRises++;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      test_done;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(nm, rd, exp);
  endtask
  // Software polls the busy bit, bounded
  task automatic wait_idle;
    logic [31:0] rd;
    logic err;
    int n;
    n = 0;
    do begin
      apb(1'b0, `ASBS_OFF_CTRL, 32'h0, rd, err);
      n++;
    end while (rd[`ASBS_BIT_TRF] !== 1'b0 && n < 4000);
    if (n >= 4000) begin
      errors++;
      test_done;
    end
    @(posedge clk);
    #1;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] rd;
    logic err;
    int base;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rxLevel = 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk("busyPin", xferInProgress, 32'h0);
    chk("portMode", serialInPortMode, 32'h1);
    chk("dataOut", serialDataOut, 32'h0);
    rdc(`ASBS_OFF_CTRL, 32'h0, "ctrl");
    apb(1'b0, 12'h03c, 32'h0, rd, err);
    chk("slverr", err, 32'h1);
    chk("unmapped", rd, 32'h0);
    // Trigger with the interface disabled is ignored
    wr(`ASBS_OFF_SHIFT, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("noStart", xferInProgress, 32'h0);
    wr(`ASBS_OFF_MODE, 32'h80);
    $display("test reset done");
    // Mode table: receive and single-shot transmit modes, single byte and full buffer
    foreach (rows[i]) begin
      for (int k = 0; k < 16; k++) wr(12'h040 + 12'(4 * k), 32'h50 + k);
      wr(`ASBS_OFF_CTRL, {24'h0, rows[i].rx, rows[i].rel, 6'h0});
      wr(`ASBS_OFF_PTR, 32'(rows[i].n - 5'h01));
      wr(`ASBS_OFF_INTV, {24'h0, rows[i].intv});
      base = sckRises;
      wr(`ASBS_OFF_SHIFT, 32'h000000a5);
      repeat (2) @(posedge clk);
      #1;
      chk("busy", xferInProgress, 32'h1);
      chk("portMode", serialInPortMode, 32'(rows[i].pinFree));
      wait_idle;
      chk("sckRises", sckRises - base, 32'(rows[i].rises));
      chk("irq", serialDoneIrq, 32'h1);
      chk("dataOut", serialDataOut, 32'h0);
      chk("lastSent", lastByte, 32'h50);
      if (rows[i].rx) rdc(`ASBS_OFF_SHIFT, 32'hff, "rxByte");
      for (int k = 0; k < 16; k++)
        rdc(12'h040 + 12'(4 * k), (rows[i].rx && k < rows[i].n) ? 32'hff : 32'h50 + k,
            "slot");
      rdc(`ASBS_OFF_FLAG, 32'h1, "flag");
      wr(`ASBS_OFF_FLAG, 32'h1);
      @(posedge clk);
      #1;
      chk("irqClr", serialDoneIrq, 32'h0);
      $display("test row %0d done", i);
    end
    // Repeat mode never ends on its own, then enable clear suspends it
    wr(`ASBS_OFF_CTRL, 32'h40);
    wr(`ASBS_OFF_PTR, 32'h2);
    wr(`ASBS_OFF_SHIFT, 32'h0);
    // CPU keeps reading the loop's first slot, holding the RAM two cycles in three; a fetch in those cycles waits for it
    for (int k = 0; k < 600; k++) rdc(12'h048, 32'h52, "repSlot");
    #1;
    chk("repBusy", xferInProgress, 32'h1);
    chk("repIrq", serialDoneIrq, 32'h0);
    wr(`ASBS_OFF_MODE, 32'h0);
    wait_idle;
    chk("suspIrq", serialDoneIrq, 32'h0);
    chk("suspOut", serialDataOut, 32'h0);
    $display("test repeat done");
    test_done;
  end
endmodule // auto_serial_buffer_sequencer_bench
`default_nettype wire

// file: hw/asbs_params.svh
// Offsets, field positions and timing counts of the auto serial sequencer
`ifndef ASBS_PARAMS_SVH
`define ASBS_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define ASBS_OFF_MODE 12'h000
`define ASBS_OFF_CTRL 12'h004
`define ASBS_OFF_INTV 12'h008
`define ASBS_OFF_PTR 12'h00c
`define ASBS_OFF_SHIFT 12'h010
`define ASBS_OFF_FLAG 12'h014
`define ASBS_RAM_PAGE 6'h01
// ****************************************
// Field positions
// ****************************************
`define ASBS_BIT_IFEN 7
`define ASBS_BIT_RXEN 7
`define ASBS_BIT_RELOAD 6
`define ASBS_BIT_TRF 3
`define ASBS_BIT_INTEN 7
`define ASBS_BIT_FLAG 0
// ****************************************
// Timing counts
// ****************************************
`define ASBS_MIN_GAP 6'h02
`define ASBS_LAST_BIT 3'h7
`endif

// file: hw/asbs_pkg.sv
// Types shared by the auto serial sequencer
package asbs_pkg;
  // Received byte with its buffer slot
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } asbs_rx_t;
  // Sequencer states
  typedef enum logic [2:0] {IDLE, LOAD, SHIFT, STORE, GAP, FINISH} asbs_state_t;
endpackage

// file: hw/asbs_top.sv
// Auto serial buffer sequencer: APB registers, buffer RAM, byte engine, FIFO
// How it works
// - Shift register write starts sequence, value discarded
// - Bytes exchanged eight bits at a time
// - Flag and interrupt after final byte
// - Data output low while not busy
// - Gap between bytes, RAM contention
// - Load, exchange, store received, decrement, reload
// - Mode from reload and receive bits
// - Transmit modes skip received write-back
// - Transmit modes release data input pin
// - Repeat mode reloads start pointer, no flag
// - Run until pointer zero slot sent
// - Enable cleared: finish byte, then suspend
// - Gap two clocks or programmed plus one, larger
`include "asbs_params.svh"
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// FIFO
// ****************************************
module asbs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, low
  input wire logic inValid, // Push request
  output logic inReady, // Room left
  input wire logic [WIDTH-1:0] inData, // Push data
  output logic outValid, // Data waiting
  input wire logic outReady, // Drain side accepts
  output logic [WIDTH-1:0] outData // Head word
);
  localparam int AW = $clog2(DEPTH);
  // Pointer width must cover the depth exactly
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("asbs_fifo DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW:0] wrPtr; // Write pointer, wrap bit on top
  logic [AW:0] rdPtr; // Read pointer
  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  // Full when the wrap bits differ and the rest match
  assign inReady = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr != rdPtr;
  assign outData = mem[rdPtr[AW-1:0]];
  // Pointers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
    end
  end
  // Storage has no reset; empty slots are never read
  always_ff @(posedge clk) begin
    if (push) mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule // asbs_fifo

// ****************************************
// Sequencer top
// ****************************************
module asbs_top #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk, // 125 MHz system clock
  input wire logic nrst, // Async reset, low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic sckIn, // Serial clock from peer
  input wire logic serialDataIn, // Serial data from peer
  output logic serialDataOut, // Serial data to peer
  output logic serialInPortMode, // Data input pin released
  output logic xferInProgress, // Sequence busy
  output logic serialDoneIrq // End of sequence
);
  logic serialIfEnable; // Interface enable
  logic rxEnable; // Receive enable
  logic repeatReload; // Repeat transmit
  logic intervalEnable; // Programmed gap enable
  logic [4:0] intervalN; // Programmed gap
  logic [3:0] bufferPointer; // Down-counting pointer
  logic [3:0] startPtr; // Pointer at start
  logic irqFlag; // Sticky end flag
  logic [7:0] shiftReg; // Serial shift register
  logic [7:0] rxLast; // Last received byte
  logic outBit; // Bit on the line
  logic [2:0] bitCnt; // Bits done
  logic [5:0] gapCnt; // Gap clocks seen
  logic [7:0] ram [16]; // Buffer RAM
  logic [31:0] rdMux; // Read selection
  asbs_pkg::asbs_state_t state; // Engine state
  asbs_pkg::asbs_rx_t fifoIn; // Push word
  asbs_pkg::asbs_rx_t fifoOut; // Head word
  logic fifoInValid, fifoInReady, fifoOutValid; // FIFO handshakes
  logic s1, s2, s3, sckLvl, sckPrev; // Clock sampler
  logic d1, d2, d3, dLvl; // Data sampler

  // ****************************************
  // Pin sampling
  // ****************************************
  // Three stages; a level is accepted once the last two agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {s1, s2, s3, sckLvl, sckPrev} <= '0;
      {d1, d2, d3, dLvl} <= '0;
    end else begin
      {s1, s2, s3} <= {sckIn, s1, s2};
      {d1, d2, d3} <= {serialDataIn, d1, d2};
      if (s2 == s3) sckLvl <= s3;
      if (d2 == d3) dLvl <= d3;
      sckPrev <= sckLvl;
    end
  end
  wire sckRise = sckLvl & ~sckPrev;
  wire sckFall = ~sckLvl & sckPrev;

  // ****************************************
  // APB decode
  // ****************************************
  wire ramHit = paddr[11:6] == `ASBS_RAM_PAGE;
  wire apbRam = psel & ramHit; // CPU owns RAM this cycle
  wire apbWr = psel & penable & pwrite;
  wire wrMode = apbWr && paddr == `ASBS_OFF_MODE;
  wire wrCtrl = apbWr && paddr == `ASBS_OFF_CTRL;
  wire wrIntv = apbWr && paddr == `ASBS_OFF_INTV;
  wire wrPtr = apbWr && paddr == `ASBS_OFF_PTR;
  wire wrFlag = apbWr && paddr == `ASBS_OFF_FLAG;
  wire trigger = apbWr && paddr == `ASBS_OFF_SHIFT && serialIfEnable;
  wire mapped = ramHit || paddr == `ASBS_OFF_MODE || paddr == `ASBS_OFF_CTRL
    || paddr == `ASBS_OFF_INTV || paddr == `ASBS_OFF_PTR
    || paddr == `ASBS_OFF_SHIFT || paddr == `ASBS_OFF_FLAG;
  assign rdMux = ramHit ? {24'h0, ram[paddr[5:2]]} :
    paddr == `ASBS_OFF_MODE ? 32'(serialIfEnable) << `ASBS_BIT_IFEN :
    paddr == `ASBS_OFF_CTRL ? (32'(rxEnable) << `ASBS_BIT_RXEN)
      | (32'(repeatReload) << `ASBS_BIT_RELOAD)
      | (32'(xferInProgress) << `ASBS_BIT_TRF) :
    paddr == `ASBS_OFF_INTV ? (32'(intervalEnable) << `ASBS_BIT_INTEN)
      | {27'h0, intervalN} :
    paddr == `ASBS_OFF_PTR ? {28'h0, bufferPointer} :
    paddr == `ASBS_OFF_SHIFT ? {24'h0, rxLast} :
    paddr == `ASBS_OFF_FLAG ? 32'(irqFlag) << `ASBS_BIT_FLAG : 32'h0;
  assign pready = 1'b1; // Zero wait states

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rdMux;
      pslverr <= !mapped;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Writes to the gap setting while busy are taken; software must avoid them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serialIfEnable <= 1'b0;
      {rxEnable, repeatReload} <= 2'h0;
      {intervalEnable, intervalN} <= 6'h00;
    end else begin
      if (wrMode) serialIfEnable <= pwdata[`ASBS_BIT_IFEN];
      if (wrCtrl) rxEnable <= pwdata[`ASBS_BIT_RXEN];
      if (wrCtrl) repeatReload <= pwdata[`ASBS_BIT_RELOAD];
      if (wrIntv) intervalEnable <= pwdata[`ASBS_BIT_INTEN];
      if (wrIntv) intervalN <= pwdata[4:0];
    end
  end

  // Flag: the end event wins over a clear in the same cycle
  wire finishNow = state == asbs_pkg::FINISH && !fifoOutValid;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) irqFlag <= 1'b0;
    else if (finishNow) irqFlag <= 1'b1;
    else if (wrFlag && pwdata[`ASBS_BIT_FLAG]) irqFlag <= 1'b0;
  end
  assign serialDoneIrq = irqFlag;

  // ****************************************
  // Engine decode
  // ****************************************
  // Receive wins when both mode bits are set
  wire repeatMode = repeatReload & ~rxEnable;
  wire ramFree = ~apbRam;
  wire [5:0] gapLimit = (intervalEnable && intervalN > 5'h01) ?
    {1'b0, intervalN} + 6'h01 : `ASBS_MIN_GAP;
  wire storeOk = state == asbs_pkg::STORE && (!rxEnable || fifoInReady);
  wire lastSlot = bufferPointer == 4'h0;
  assign fifoInValid = state == asbs_pkg::STORE && rxEnable;
  assign fifoIn = '{addr: bufferPointer, data: shiftReg};
  assign serialDataOut = xferInProgress & outBit;
  assign serialInPortMode = ~(xferInProgress & rxEnable);

  // ****************************************
  // Byte engine
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= asbs_pkg::IDLE;
      xferInProgress <= 1'b0;
      {bufferPointer, startPtr} <= 8'h00;
      {shiftReg, rxLast} <= 16'h0000;
      outBit <= 1'b0;
      bitCnt <= 3'h0;
      gapCnt <= 6'h00;
    end else begin
      unique case (state)
        asbs_pkg::IDLE: begin
          if (wrPtr) bufferPointer <= pwdata[3:0];
          if (trigger) begin
            xferInProgress <= 1'b1;
            startPtr <= bufferPointer;
            state <= asbs_pkg::LOAD;
          end
        end
        asbs_pkg::LOAD: begin
          // Waits while the CPU holds the RAM
          if (ramFree) begin
            shiftReg <= ram[bufferPointer];
            outBit <= ram[bufferPointer][7];
            bitCnt <= 3'h0;
            state <= asbs_pkg::SHIFT;
          end
        end
        asbs_pkg::SHIFT: begin
          // Drive on falling, sample on rising, MSB first
          if (sckFall) outBit <= shiftReg[7];
          if (sckRise) begin
            shiftReg <= {shiftReg[6:0], dLvl};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == `ASBS_LAST_BIT) state <= asbs_pkg::STORE;
          end
        end
        asbs_pkg::STORE: begin
          if (storeOk) begin
            rxLast <= shiftReg;
            gapCnt <= 6'h00;
            if (lastSlot && !repeatMode) begin
              state <= asbs_pkg::FINISH;
            end else begin
              bufferPointer <= lastSlot ? startPtr : bufferPointer - 4'h1;
              if (!serialIfEnable) begin
                xferInProgress <= 1'b0;
                state <= asbs_pkg::IDLE;
              end else begin
                state <= asbs_pkg::GAP;
              end
            end
          end
        end
        asbs_pkg::GAP: begin
          if (sckRise) begin
            gapCnt <= gapCnt + 6'h01;
            if (gapCnt + 6'h01 >= gapLimit) state <= asbs_pkg::LOAD;
          end
        end
        asbs_pkg::FINISH: begin
          // On finish, busy drops only once every received byte sits in RAM; a suspend from STORE drops it at once
          if (!fifoOutValid) begin
            xferInProgress <= 1'b0;
            state <= asbs_pkg::IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Receive path and buffer RAM
  // ****************************************
  // FIFO decouples the link from CPU contention on the RAM
  asbs_fifo #(.WIDTH(12), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(ramFree),
    .outData(fifoOut)
  );
  // CPU and drain never write together: drain waits on ramFree
  always_ff @(posedge clk) begin
    if (apbWr && ramHit) ram[paddr[5:2]] <= pwdata[7:0];
    else if (fifoOutValid && ramFree) ram[fifoOut.addr] <= fifoOut.data;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence byteDone;
    state == asbs_pkg::SHIFT && sckRise && bitCnt == `ASBS_LAST_BIT;
  endsequence
  a_trigger_start: assert property (state == asbs_pkg::IDLE && trigger
    |=> xferInProgress && state == asbs_pkg::LOAD) else $error("no start");
  a_byte_eight: assert property (byteDone |=> state == asbs_pkg::STORE)
    else $error("byte not eight bits");
  a_done_flag: assert property (finishNow |=> irqFlag && !xferInProgress)
    else $error("end flag missing");
  a_idle_low: assert property (!xferInProgress |-> !serialDataOut)
    else $error("output not low");
  a_gap_min: assert property (state == asbs_pkg::GAP && gapCnt == 6'h00
    |=> state != asbs_pkg::LOAD) else $error("gap too short");
  a_ptr_step: assert property (storeOk && !lastSlot && rxEnable
    |=> bufferPointer == $past(bufferPointer) - 4'h1) else $error("bad step");
  a_no_rx_push: assert property (!rxEnable |-> !fifoInValid)
    else $error("write-back in transmit mode");
  a_pin_release: assert property (xferInProgress && !rxEnable
    |-> serialInPortMode) else $error("pin not released");
  a_repeat_reload: assert property (storeOk && lastSlot && repeatMode
    && serialIfEnable |=> bufferPointer == $past(startPtr)
    && state == asbs_pkg::GAP && !$rose(irqFlag)) else $error("no reload");
  a_last_end: assert property (storeOk && lastSlot && !repeatMode
    |=> state == asbs_pkg::FINISH) else $error("no finish");
  a_suspend: assert property (storeOk && !serialIfEnable
    && !(lastSlot && !repeatMode) |=> !xferInProgress) else $error("no suspend");
  a_ram_addr: assert property (state == asbs_pkg::LOAD && ramFree
    |=> shiftReg == $past(ram[bufferPointer])) else $error("bad fetch");
endmodule // asbs_top
`default_nettype wire
